// >>> pkg/sac_pkg.sv
package sac_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_PINCFG  = 8'h04;
  localparam logic [7:0]  OFS_RESULT  = 8'h08;
  localparam logic [7:0]  OFS_ISTAT   = 8'h0c;
  localparam logic [7:0]  OFS_IMASK   = 8'h10;

  // ----------------------------------------------------------------
  // converter_control fields
  // ----------------------------------------------------------------
  localparam int          CTL_CLK_HI  = 7;
  localparam int          CTL_CLK_LO  = 6;
  localparam int          CTL_CH_HI   = 4;
  localparam int          CTL_CH_LO   = 3;
  localparam int          CTL_GO      = 2;
  localparam int          CTL_FLAG    = 1;
  localparam int          CTL_PWR     = 0;
  localparam logic [7:0]  CTRL_RST    = 8'h00;

  // ----------------------------------------------------------------
  // pin_analog_config fields, interrupt bits
  // ----------------------------------------------------------------
  localparam int          PIN_REF_BIT = 4;
  localparam logic [4:0]  PINCFG_RST  = 5'h00;
  localparam int          IST_DONE    = 0;
  localparam int          IST_ABORT   = 1;
  localparam logic [1:0]  IRQ_RST     = 2'h0;

  // ----------------------------------------------------------------
  // conversion clock and timing, bus response codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  CLK_DIV2    = 2'h0;
  localparam logic [1:0]  CLK_DIV8    = 2'h1;
  localparam logic [1:0]  CLK_DIV32   = 2'h2;
  localparam logic [1:0]  CLK_RC      = 2'h3;
  localparam logic [5:0]  DIV2_N      = 6'h02;
  localparam logic [5:0]  DIV8_N      = 6'h08;
  localparam logic [5:0]  DIV32_N     = 6'h20;
  localparam logic [5:0]  RC_DIV_N    = 6'h19;
  localparam logic [3:0]  SAMPLE_TICKS = 4'h2;
  localparam logic [3:0]  SETTLE_TICKS = 4'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_TRIAL  = 4'b0100,
    ST_FINISH = 4'b1000
  } sac_state_t;

  typedef struct packed {
    logic       sample_en;
    logic [1:0] channel;
    logic       ref_ext;
    logic [3:0] analog_en;
    logic [7:0] trial;
  } sac_ana_t;

endpackage

// >>> hw/sac_sync3.sv
`timescale 1ns/1ns
`default_nettype none
module sac_sync3 (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin side
  input  wire logic din,
  // filtered level
  output logic      dout
);
  import sac_pkg::*;

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout <= 1'b0;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end

endmodule
`default_nettype wire

// >>> hw/sac_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
module sac_clkdiv (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  input  wire logic       sleep,
  // conversion clock enable
  output logic            tick
);
  import sac_pkg::*;

  logic [5:0] sys_cnt_r;
  logic [5:0] rc_cnt_r;
  logic [5:0] sys_n;

  always_comb begin
    case (clk_sel)
      CLK_DIV2: sys_n = DIV2_N;
      CLK_DIV8: sys_n = DIV8_N;
      default:  sys_n = DIV32_N;
    endcase
  end

  // system oscillator divider, frozen while the core sleeps
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || sys_cnt_r >= sys_n - 6'h01) begin
      sys_cnt_r <= 6'h00;
    end else if (!sleep) begin
      sys_cnt_r <= sys_cnt_r + 6'h01;
    end
  end

  // private rc clock keeps running through sleep
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || rc_cnt_r == RC_DIV_N - 6'h01) begin
      rc_cnt_r <= 6'h00;
    end else begin
      rc_cnt_r <= rc_cnt_r + 6'h01;
    end
  end

  // (RL7) clock source choice
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      tick <= 1'b0;
    end else if (clk_sel == CLK_RC) begin
      tick <= (rc_cnt_r == RC_DIV_N - 6'h01);
    end else begin
      tick <= !sleep && (sys_cnt_r == sys_n - 6'h01);
    end
  end

endmodule
`default_nettype wire

// >>> hw/sac_top.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (RL1) four analog channels, any one routed to the sample-and-hold
// (RL2) each conversion yields an 8-bit unsigned result
// (RL3) successive approximation settles one bit per step, msb first
// (RL4) software picks supply or reference pin as positive reference
// (RL5) conversion continues through sleep when run from the rc clock
// (RL6) software selects the rc clock before relying on sleep conversion
// (RL7) clock select 00 /2, 01 /8, 10 /32, 11 internal rc clock
// (RL8) per-pin analog or digital setting; pin 3 may act as reference
// (RL9) control layout clk[7:6], 0, chan[4:3], go, flag, power; reset 0
// (RL10) channel code 00..11 routes inputs 0..3
// (RL11) go with power starts; completion clears go, loads result, sets flag
module sac_top (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // axi4-lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // axi4-lite read
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // core state
  input  wire logic                sleep_mode,
  // analog front end
  input  wire logic                cmp_in,
  output sac_pkg::sac_ana_t        ana_o,
  // interrupt
  output logic                     irq
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]  aw_addr_r;
  logic        aw_got_r;
  logic [7:0]  w_data_r;
  logic        w_lane0_r;
  logic        w_got_r;
  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_pincfg;
  logic        wr_istat;
  logic        wr_imask;

  logic [1:0]  clk_sel_r;
  logic [1:0]  chan_r;
  logic        go_r;
  logic        flag_r;
  logic        pwr_r;
  logic [4:0]  pincfg_r;
  logic [7:0]  result_r;
  logic [1:0]  istat_r;
  logic [1:0]  istat_nxt;
  logic [1:0]  imask_r;

  sac_state_t  state_r;
  logic [3:0]  cnt_r;
  logic [2:0]  bit_r;
  logic [7:0]  trial_r;
  logic [1:0]  conv_ch_r;
  logic        tick;
  logic        cmp_f;
  logic        busy;
  logic        abort;
  logic        done_evt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = addr_is(a, OFS_CTRL) || addr_is(a, OFS_PINCFG) ||
             addr_is(a, OFS_RESULT) || addr_is(a, OFS_ISTAT) ||
             addr_is(a, OFS_IMASK);
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  sac_clkdiv u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (pwr_r),
    .clk_sel (clk_sel_r),
    .sleep   (sleep_mode),
    .tick    (tick)
  );

  sac_sync3 u_cmp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (cmp_in),
    .dout    (cmp_f)
  );

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are taken in either order, held until both exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_got_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_r      <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_r      <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_got_r      <= 1'b0;
      w_data_r     <= 8'h00;
      w_lane0_r    <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_r      <= 1'b1;
      w_data_r     <= s_axi_wdata[7:0];
      w_lane0_r    <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_got_r      <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_fire   = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ctrl   = wr_fire && w_lane0_r && addr_is(aw_addr_r, OFS_CTRL);
  assign wr_pincfg = wr_fire && w_lane0_r && addr_is(aw_addr_r, OFS_PINCFG);
  assign wr_istat  = wr_fire && w_lane0_r && addr_is(aw_addr_r, OFS_ISTAT);
  assign wr_imask  = wr_fire && w_lane0_r && addr_is(aw_addr_r, OFS_IMASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (addr_is(s_axi_araddr, OFS_CTRL)) begin
        // (RL9) control readback
        s_axi_rdata <= {24'h000000, clk_sel_r, 1'b0, chan_r, go_r, flag_r, pwr_r};
      end else if (addr_is(s_axi_araddr, OFS_PINCFG)) begin
        s_axi_rdata <= {27'h0000000, pincfg_r};
      end else if (addr_is(s_axi_araddr, OFS_RESULT)) begin
        s_axi_rdata <= {24'h000000, result_r};
      end else if (addr_is(s_axi_araddr, OFS_ISTAT)) begin
        s_axi_rdata <= {30'h00000000, istat_r};
      end else if (addr_is(s_axi_araddr, OFS_IMASK)) begin
        s_axi_rdata <= {30'h00000000, imask_r};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // converter_control
  // ----------------------------------------------------------------
  // (RL9) plain fields reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sel_r <= CTRL_RST[CTL_CLK_HI:CTL_CLK_LO];
      chan_r    <= CTRL_RST[CTL_CH_HI:CTL_CH_LO];
      pwr_r     <= CTRL_RST[CTL_PWR];
    end else if (wr_ctrl) begin
      clk_sel_r <= w_data_r[CTL_CLK_HI:CTL_CLK_LO];
      chan_r    <= w_data_r[CTL_CH_HI:CTL_CH_LO];
      pwr_r     <= w_data_r[CTL_PWR];
    end
  end

  // (RL11) go needs power, hardware clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_r <= CTRL_RST[CTL_GO];
    end else if (done_evt || abort) begin
      go_r <= 1'b0;
    end else if (wr_ctrl) begin
      go_r <= w_data_r[CTL_GO] && (go_r || w_data_r[CTL_PWR]);
    end
  end

  // (RL11) completion sets flag, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= CTRL_RST[CTL_FLAG];
    end else if (done_evt) begin
      flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      flag_r <= w_data_r[CTL_FLAG];
    end
  end

  // ----------------------------------------------------------------
  // pin_analog_config
  // ----------------------------------------------------------------
  // (RL8) pin mode and reference select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pincfg_r <= PINCFG_RST;
    end else if (wr_pincfg) begin
      pincfg_r <= w_data_r[4:0];
    end
  end

  // ----------------------------------------------------------------
  // successive approximation engine
  // ----------------------------------------------------------------
  assign busy     = (state_r == ST_SAMPLE) || (state_r == ST_TRIAL);
  assign abort    = busy && (!go_r || !pwr_r);
  assign done_evt = (state_r == ST_FINISH);

  // (RL5) ticks keep coming in sleep only on the rc clock
  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      bit_r     <= 3'h7;
      trial_r   <= 8'h00;
      conv_ch_r <= 2'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go_r && pwr_r) begin
            // (RL10) channel latched for the whole conversion
            conv_ch_r <= chan_r;
            cnt_r     <= SAMPLE_TICKS - 4'h1;
            state_r   <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (cnt_r == 4'h0) begin
              // (RL3) first trial at the msb
              trial_r <= 8'h80;
              bit_r   <= 3'h7;
              cnt_r   <= SETTLE_TICKS - 4'h1;
              state_r <= ST_TRIAL;
            end else begin
              cnt_r <= cnt_r - 4'h1;
            end
          end
        end
        ST_TRIAL: begin
          if (tick) begin
            if (cnt_r != 4'h0) begin
              cnt_r <= cnt_r - 4'h1;
            end else begin
              // (RL3) keep or drop this bit, try the next
              trial_r[bit_r] <= cmp_f;
              cnt_r          <= SETTLE_TICKS - 4'h1;
              if (bit_r == 3'h0) begin
                state_r <= ST_FINISH;
              end else begin
                trial_r[bit_r - 3'h1] <= 1'b1;
                bit_r                 <= bit_r - 3'h1;
              end
            end
          end
        end
        ST_FINISH: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // (RL2) 8-bit result loaded at completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= 8'h00;
    end else if (done_evt) begin
      result_r <= trial_r;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // write-one-to-clear, a new event in the same cycle wins
  always_comb begin
    istat_nxt = istat_r;
    if (wr_istat) begin
      istat_nxt = istat_nxt & ~w_data_r[1:0];
    end
    istat_nxt[IST_DONE]  = istat_nxt[IST_DONE] | done_evt;
    istat_nxt[IST_ABORT] = istat_nxt[IST_ABORT] | abort;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= IRQ_RST;
    end else begin
      istat_r <= istat_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_r <= IRQ_RST;
    end else if (wr_imask) begin
      imask_r <= w_data_r[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_r & imask_r);
    end
  end

  // ----------------------------------------------------------------
  // analog front end drive
  // ----------------------------------------------------------------
  // one cycle behind the engine; the settle ticks cover that lag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_o <= '0;
    end else begin
      ana_o.sample_en <= (state_r == ST_SAMPLE);
      // (RL1) (RL10) mux follows the latched channel while busy
      ana_o.channel   <= busy ? conv_ch_r : chan_r;
      // (RL4) external reference from pin 3
      ana_o.ref_ext   <= pincfg_r[PIN_REF_BIT];
      // (RL8) pins set analog disable their digital buffers
      ana_o.analog_en <= pincfg_r[3:0] | {pincfg_r[PIN_REF_BIT], 3'h0};
      ana_o.trial     <= trial_r;
    end
  end

endmodule
`default_nettype wire

// >>> sim/sac_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// bus and front-end checks
// ----------------------------------------------------------------
module sac_checker
  import sac_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // analog side
  input wire sac_ana_t    ana_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence

  property p_b_answer; s_wr_taken |=> ##1 s_axi_bvalid; endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_ready_back; s_b_done |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready); endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("write readies not restored");
  property p_busy_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("second write accepted");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  // unmapped reads answer an error with zero data
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > OFS_IMASK[7:2]
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_ref_pin; ana_o.ref_ext |-> ana_o.analog_en[3]; endproperty
  a_ref_pin: assert property (p_ref_pin)
    else $error("reference pin left digital");
endmodule

bind sac_top sac_checker sac_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .ana_o);
`default_nettype wire

// >>> sim/sac_afe_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// comparator and input pins; no hold droop modelled
// ----------------------------------------------------------------
module sac_afe_model
  import sac_pkg::*;
(
  // trial code and routing from the block
  input wire sac_ana_t    ana,
  // pin levels, channel n in byte n, 255 = supply
  input wire logic [31:0] vin,
  input wire logic [7:0]  vref,
  // comparator decision
  output logic            cmp
);
  assign cmp = int'(vin[{ana.channel, 3'b000} +: 8]) * 255 >=
               int'(ana.trial) * (ana.ref_ext ? int'(vref) : 255);
endmodule
`default_nettype wire

// >>> sim/tb_sac_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sac_top;
  import sac_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, sleep_mode = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic        awr, wrdy, bv, arr, rv, cmp, irq;
  logic [7:0]  awa = 8'h00, ara = 8'h00, vref = 8'hff;
  logic [31:0] wd = 32'h0, rdata, rdv;
  logic [31:0] vin = 32'hff3ca500;
  logic [3:0]  ws = 4'h0;
  logic [1:0]  bresp, rresp, br, rr;
  sac_ana_t    ana;
  int          err_count = 0, n_tests = 0, n;
  int          nt[4];

  always #10 aclk = ~aclk;

  sac_top sac_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .sleep_mode(sleep_mode), .cmp_in(cmp), .ana_o(ana), .irq(irq));
  sac_afe_model sac_afe_model_inst (.ana(ana), .vin(vin), .vref(vref), .cmp(cmp));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // the first edge keeps a new request off the edge that closed the last one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awa <= a; wd <= {24'h0, d}; ws <= 4'h1; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) begin br = bresp; bre <= 1'b0; end
    end while (!bv);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) begin rdv = rdata; rr = rresp; rre <= 1'b0; end
    end while (!rv);
  endtask

  // power drops first so every start sees the divider from its zero count;
  // done bit is cleared afterwards so the next wait sees a fresh edge
  task automatic conv(input logic [7:0] c, input int k);
    if (c != 8'h00) begin
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CTRL, c);
    end
    n = 0;
    while (!irq && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (k >= 0) chk(n >= 26 * nt[k] - 4 && n <= 27 * nt[k] + 8, 1);
    wr(OFS_ISTAT, 8'h01);
  endtask

  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    nt = '{2, 8, 32, int'(RC_DIV_N)};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4));
      chk(rdv, 32'h0);
    end
    rd(8'h14);
    chk(rr, RESP_SLVERR);
    chk(rdv, 32'h0);
    wr(8'h20, 8'hff);
    chk(br, RESP_SLVERR);
    wr(OFS_CTRL, 8'hfa);
    rd(OFS_CTRL);
    chk(rdv, 32'hda);
    wr(OFS_CTRL, 8'h04);
    rd(OFS_CTRL);
    chk(rdv, 32'h0);
    wr(OFS_RESULT, 8'h55);
    rd(OFS_RESULT);
    chk(br, RESP_OKAY);
    chk(rdv, 32'h0);
    wr(OFS_PINCFG, 8'h05);
    // front-end outputs follow the register one cycle later
    @(posedge aclk);
    chk({ana.ref_ext, ana.analog_en}, 32'h05);
    // ----------------------------------------------------------------
    // conversions
    // ----------------------------------------------------------------
    wr(OFS_PINCFG, 8'h10);
    @(posedge aclk);
    chk({ana.ref_ext, ana.analog_en[3]}, 32'h3);
    vref <= 8'h80;
    wr(OFS_IMASK, 8'h01);
    for (int k = 0; k < 4; k++) begin
      conv({2'(k), 6'h15}, k);
      rd(OFS_RESULT);
      chk(rdv, 32'h77);
    end
    wr(OFS_PINCFG, 8'h0f);
    for (int ch = 0; ch < 4; ch++) begin
      conv({3'b010, 2'(ch), 3'b101}, 1);
      rd(OFS_RESULT);
      chk(rdv, {24'h0, vin[ch * 8 +: 8]});
      rd(OFS_CTRL);
      chk(rdv, {24'h0, 3'b010, 2'(ch), 3'b011});
      chk(ana.channel, ch);
    end
    // fast clock stalls in sleep, rc clock keeps going
    sleep_mode <= 1'b1;
    wr(OFS_CTRL, 8'h15);
    repeat (300) @(posedge aclk);
    chk(irq, 1'b0);
    chk(ana.sample_en, 1'b1);
    sleep_mode <= 1'b0;
    conv(8'h00, -1);
    chk(n <= 62, 1);
    sleep_mode <= 1'b1;
    conv(8'hd5, 3);
    sleep_mode <= 1'b0;
    rd(OFS_RESULT);
    chk(rdv, 32'h3c);
    // ----------------------------------------------------------------
    // abort and interrupt
    // ----------------------------------------------------------------
    wr(OFS_IMASK, 8'h03);
    wr(OFS_CTRL, 8'h55);
    repeat (50) @(posedge aclk);
    wr(OFS_CTRL, 8'h52);
    repeat (2) @(posedge aclk);
    rd(OFS_ISTAT);
    chk(irq, 1'b1);
    chk(rdv, 32'h2);
    rd(OFS_CTRL);
    chk(rdv, 32'h52);
    wr(OFS_IMASK, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(OFS_ISTAT, 8'h02);
    rd(OFS_ISTAT);
    chk(rdv, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
